//--- library_entry_select.sv
// airframe strap decode and library entry selection
// assumes strap lines arrive asynchronous, grounded line reads low; avalon-mm slave on core_clk
//
// The Avalon-MM register port and the address map were chosen for this implementation.
module library_entry_select import loader_select_pkg::*; #(
   parameter int DEPTH = 32,
   parameter int IW = 5
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [4:0] type_line_n,
   input wire logic [3:0] cfg_line_n,
   output logic cable_prompt_message,
   output logic subtype_query,
   output logic coupling_direct,
   output logic center_tap_gnd,
   output logic [4:0] own_rt_addr,
   output logic xfer_start,
   output logic [IW-1:0] xfer_entry,
   output logic select_error
);

   // one-hot or all-zero computer file id
   function automatic logic fid_ok(input logic [3:0] f);
      return (f & (f - 4'h1)) == 4'h0;
   endfunction

   // own terminal address; avoids the controller and broadcast codes
   function automatic logic [4:0] rt_addr_f(input logic [4:0] t, input logic [3:0] c, input logic [3:0] b);
      logic [4:0] s;
      s = t + {1'b0, c} + {1'b0, b};
      return (s == TA_BC || s == RT_BCAST) ? RT_SPARE : s;
   endfunction

   // stored words for one transaction of n data words
   function automatic logic [15:0] words_f(input logic [3:0] p, input logic [15:0] n);
      return (p < PROTO_BASIC_N) ? HDR_WORDS + n + TRL_WORDS : n;
   endfunction

   logic [4:0] type_s1_q, type_s2_q;
   logic [3:0] cfg_s1_q, cfg_s2_q;
   logic ack_q;
   logic acc_wr, acc_rd;
   logic [31:0] ent0_q [DEPTH];
   logic [31:0] ent1_q [DEPTH];
   boot_t boot_q;
   scan_t scan_q;
   logic [15:0] bit_cnt_q;
   logic bit_done_q;
   logic [4:0] type_q;
   logic [3:0] cfg_q;
   target_t tgt_q;
   logic [15:0] xfer_n_q;
   logic [IW-1:0] eidx_q, idx_q, res_q;
   logic [3:0] phy_bus_q;
   logic phy_dir_q, phy_ct_q;
   logic found_q, patch_q, err_q, need_q, is_bc_q;
   logic [3:0] res_proto_q;
   entry_w0_t e0;
   entry_w1_t e1;
   logic base, sub_ok, patch_hit, full_hit, last;
   logic attached, reserved;
   logic [31:0] rd_d;

   // two-flop synchronisers for the strap lines
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         type_s1_q <= 5'h1F;
         type_s2_q <= 5'h1F;
         cfg_s1_q <= 4'hF;
         cfg_s2_q <= 4'hF;
      end else if (ce) begin
         type_s1_q <= type_line_n;
         type_s2_q <= type_s1_q;
         cfg_s1_q <= cfg_line_n;
         cfg_s2_q <= cfg_s1_q;
      end
   end

   assign attached = type_s2_q != 5'h1F;
   assign reserved = type_q == TYPE_RESERVED;

   // one wait state: request taken on the second edge it is held; a low ce holds the answer off
   // so that a write is never acknowledged in a cycle in which it cannot land
   assign waitrequest = (read | write) & ~(ack_q & ce);
   assign acc_wr = write & ack_q & ce;
   assign acc_rd = read & ~ack_q & ce;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         ack_q <= 1'b0;
      else if (ce)
         ack_q <= (read | write) & ~ack_q;
   end

   // read mux, captured one cycle ahead so read data come from flops
   always_comb begin
      rd_d = RST_ZERO;
      case (address)
         A_STAT: rd_d = {12'h0, cfg_q, type_q, center_tap_gnd, coupling_direct, bit_done_q,
                         cable_prompt_message, attached, patch_q, is_bc_q, need_q, err_q, found_q,
                         scan_q != S_IDLE};
         A_TGT: rd_d = tgt_q;
         A_XFER: rd_d = {16'h0, xfer_n_q};
         A_RES: rd_d = {words_f(res_proto_q, xfer_n_q), 3'h0, own_rt_addr, 8'(res_q)};
         A_EIDX: rd_d = 32'(eidx_q);
         A_EW0: rd_d = ent0_q[eidx_q];
         A_EW1: rd_d = ent1_q[eidx_q];
         A_PHY: rd_d = {24'h0, phy_bus_q, 2'h0, phy_ct_q, phy_dir_q};
         default: rd_d = RST_ZERO;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         readdata <= RST_ZERO;
      else if (acc_rd)
         readdata <= rd_d;
   end

   // software owned configuration registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tgt_q <= '0;
         xfer_n_q <= 16'h0;
         eidx_q <= '0;
         phy_bus_q <= 4'h0;
         phy_dir_q <= 1'b0;
         phy_ct_q <= 1'b0;
      end else if (acc_wr) begin
         case (address)
            A_TGT: tgt_q <= writedata;
            A_XFER: xfer_n_q <= writedata[15:0];
            A_EIDX: eidx_q <= writedata[IW-1:0];
            A_PHY: begin
               phy_dir_q <= writedata[0];
               phy_ct_q <= writedata[1];
               phy_bus_q <= writedata[7:4];
            end
            default: ;
         endcase
      end
   end

   // library entry store, no reset: contents are loaded by software
   always_ff @(posedge core_clk) begin
      if (acc_wr && address == A_EW0)
         ent0_q[eidx_q] <= writedata;
      if (acc_wr && address == A_EW1)
         ent1_q[eidx_q] <= writedata;
   end

   // power-on sequence: self test, then type lines, then configuration lines
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_q <= B_BIT;
         bit_cnt_q <= 16'h0;
         bit_done_q <= 1'b0;
         type_q <= 5'h0;
         cfg_q <= 4'h0;
      end else if (ce) begin
         case (boot_q)
            B_BIT: begin
               if (bit_cnt_q == 16'(BIT_CYC - 1)) begin
                  bit_done_q <= 1'b1;
                  boot_q <= B_TYPE;
               end
               bit_cnt_q <= bit_cnt_q + 16'h1;
            end
            B_TYPE: begin
               if (attached) begin
                  type_q <= ~type_s2_q;
                  boot_q <= B_CFG;
               end else
                  boot_q <= B_PROMPT;
            end
            B_CFG: begin
               // reserved type leaves the configuration at zero
               cfg_q <= reserved ? 4'h0 : ~cfg_s2_q;
               boot_q <= B_READY;
            end
            B_PROMPT: begin
               // operator says cables are on; the loop test is simply repeated
               if (acc_wr && address == A_CTRL && writedata[C_CABLE_ACK])
                  boot_q <= B_TYPE;
            end
            B_READY: begin
               if (acc_wr && address == A_CTRL && writedata[C_RERUN]) begin
                  boot_q <= B_BIT;
                  bit_cnt_q <= 16'h0;
                  bit_done_q <= 1'b0;
               end
            end
            default: boot_q <= B_BIT;
         endcase
      end
   end

   // physical bus outputs and own address follow the decoded airframe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cable_prompt_message <= 1'b0;
         coupling_direct <= 1'b0;
         center_tap_gnd <= 1'b0;
         own_rt_addr <= 5'h0;
      end else if (ce) begin
         cable_prompt_message <= boot_q == B_PROMPT;
         coupling_direct <= reserved | phy_dir_q;
         center_tap_gnd <= reserved | phy_ct_q;
         own_rt_addr <= rt_addr_f(type_q, cfg_q, phy_bus_q);
      end
   end

   // candidate test for the entry under the scan pointer
   always_comb begin
      e0 = ent0_q[idx_q];
      e1 = ent1_q[idx_q];
      base = e0.valid && e0.cfg == cfg_q && e0.bus == tgt_q.bus
             && e0.ta == tgt_q.ta
             && e0.fid == tgt_q.fid && fid_ok(e0.fid)
             && e1.name_len >= NAME_MIN
             && e0.subtype != SUB_BAD;
      // zero subtype is the common case; otherwise it must match the operator answer
      sub_ok = e0.subtype == SUB_NONE || e0.subtype == tgt_q.sub_ans;
      patch_hit = base && sub_ok && e0.patch && tgt_q.mcm_ok
                  && e1.memcfg == tgt_q.cur_cfg;
      full_hit = base && sub_ok && !e0.patch && tgt_q.cur_cfg < e1.memcfg;
      last = idx_q == IW'(DEPTH - 1);
   end

   // scan over all entries, one per cycle; a patch hit ends the scan early
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_q <= S_IDLE;
         idx_q <= '0;
         res_q <= '0;
         res_proto_q <= 4'h0;
         found_q <= 1'b0;
         patch_q <= 1'b0;
         need_q <= 1'b0;
         is_bc_q <= 1'b0;
      end else if (ce) begin
         case (scan_q)
            S_IDLE: begin
               if (acc_wr && address == A_CTRL && writedata[C_START] && boot_q == B_READY) begin
                  scan_q <= S_SCAN;
                  idx_q <= '0;
                  found_q <= 1'b0;
                  patch_q <= 1'b0;
                  need_q <= 1'b0;
               end
            end
            S_SCAN: begin
               // stores subtype unanswered: raise the operator query
               if (base && e0.subtype != SUB_NONE && tgt_q.sub_ans == SUB_NONE)
                  need_q <= 1'b1;
               if (patch_hit || (full_hit && !found_q)) begin
                  res_q <= idx_q;
                  res_proto_q <= e0.proto;
                  is_bc_q <= e0.ta == TA_BC;
                  found_q <= 1'b1;
                  patch_q <= patch_hit;
               end
               if (patch_hit || last)
                  scan_q <= S_DONE;
               idx_q <= idx_q + IW'(1);
            end
            S_DONE: scan_q <= S_IDLE;
            default: scan_q <= S_IDLE;
         endcase
      end
   end

   // result strobe and sticky error; a new start clears the error
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xfer_start <= 1'b0;
         xfer_entry <= '0;
         select_error <= 1'b0;
         err_q <= 1'b0;
         subtype_query <= 1'b0;
      end else if (ce) begin
         xfer_start <= scan_q == S_DONE && found_q;
         subtype_query <= need_q;
         if (scan_q == S_DONE) begin
            xfer_entry <= res_q;
            err_q <= !found_q;
            select_error <= !found_q;
         end else if (scan_q == S_IDLE && boot_q == B_READY && acc_wr && address == A_CTRL
                      && writedata[C_START]) begin
            err_q <= 1'b0;
            select_error <= 1'b0;
         end
      end
   end

endmodule

//--- loader_select_pkg.sv
// constants, types and register map of the library entry selector
// assumes one 100 MHz clock domain and an avalon-mm master on the register side
package loader_select_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIT_TIME_NS = 10000;
   localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // register byte addresses
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_STAT = 6'h04;
   localparam logic [5:0] A_TGT = 6'h08;
   localparam logic [5:0] A_XFER = 6'h0C;
   localparam logic [5:0] A_RES = 6'h10;
   localparam logic [5:0] A_EIDX = 6'h14;
   localparam logic [5:0] A_EW0 = 6'h18;
   localparam logic [5:0] A_EW1 = 6'h1C;
   localparam logic [5:0] A_PHY = 6'h20;
   // control bits
   localparam int C_START = 0;
   localparam int C_CABLE_ACK = 1;
   localparam int C_RERUN = 2;
   // numbers of the lines and descriptor fields
   localparam logic [4:0] TYPE_RESERVED = 5'h1F;
   localparam logic [4:0] TA_BC = 5'h00;
   localparam logic [4:0] RT_SPARE = 5'h1E;
   localparam logic [4:0] RT_BCAST = 5'h1F;
   localparam logic [1:0] SUB_NONE = 2'h0;
   localparam logic [1:0] SUB_BAD = 2'h3;
   localparam logic [7:0] NAME_MIN = 8'h08;
   localparam logic [3:0] PROTO_BASIC_N = 4'h2;
   localparam logic [15:0] HDR_WORDS = 16'h0004;
   localparam logic [15:0] TRL_WORDS = 16'h0002;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic [6:0] rsv;
      logic valid;
      logic patch;
      logic [1:0] subtype;
      logic [3:0] proto;
      logic [3:0] fid;
      logic [4:0] ta;
      logic [3:0] bus;
      logic [3:0] cfg;
   } entry_w0_t;

   typedef struct packed {
      logic [15:0] rsv;
      logic [7:0] name_len;
      logic [7:0] memcfg;
   } entry_w1_t;

   typedef struct packed {
      logic [7:0] rsv;
      logic [7:0] cur_cfg;
      logic [1:0] sub_ans;
      logic mcm_ok;
      logic [3:0] fid;
      logic [4:0] ta;
      logic [3:0] bus;
   } target_t;

   typedef enum logic [4:0] {
      B_BIT = 5'b00001,
      B_TYPE = 5'b00010,
      B_CFG = 5'b00100,
      B_READY = 5'b01000,
      B_PROMPT = 5'b10000
   } boot_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_SCAN = 3'b010,
      S_DONE = 3'b100
   } scan_t;
endpackage

//--- strap_model.sv
// aircraft strap lines as the loader sees them
// assumes open straps are pulled up, so only a grounded strap reads low
module strap_model (
   input wire logic [4:0] type_gnd,
   input wire logic [3:0] cfg_gnd,
   output logic [4:0] type_line_n,
   output logic [3:0] cfg_line_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // grounded strap pulls its line low, open strap goes to the pull-up level
   assign type_line_n = ~type_gnd;
   assign cfg_line_n = ~cfg_gnd;
endmodule

//--- library_entry_select_asserts.sv
// port checker of the library entry selector
// assumes ce tied high and the 1000-cycle self test after reset
module library_entry_select_asserts import loader_select_pkg::*; #(
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic waitrequest,
   input wire logic [4:0] type_line_n,
   input wire logic cable_prompt_message,
   input wire logic coupling_direct,
   input wire logic [4:0] own_rt_addr,
   input wire logic xfer_start,
   input wire logic select_error
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] up_q;
   logic [7:0] since_q;
   logic phy_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // saturating counters so a long run never wraps into a false pass
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         up_q <= 11'h000;
      else if (up_q != 11'h7FF)
         up_q <= up_q + 11'h001;
   end
   // cycles since the last start write taken on the bus
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         since_q <= 8'hFF;
      else if (write && !waitrequest && address == A_CTRL && writedata[C_START])
         since_q <= 8'h00;
      else if (since_q != 8'hFF)
         since_q <= since_q + 8'h01;
   end
   // software coupling bits mask the strap-only view of coupling
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         phy_q <= 1'b0;
      else if (write && !waitrequest && address == A_PHY)
         phy_q <= writedata[1:0] != 2'h0;
   end
   sequence s_req_rise;
      $rose(read || write);
   endsequence
   sequence s_one_wait;
      waitrequest ##1 !waitrequest;
   endsequence
   a_one_wait: assert property (s_req_rise |-> s_one_wait)
      else $error("bus answer not after exactly one wait state");
   a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest high with no request");
   a_bit_first: assert property (cable_prompt_message |-> up_q >= 11'h3E8)
      else $error("cable prompt before self test finished");
   a_prompt_open: assert property ($rose(cable_prompt_message) |-> $past(type_line_n, 4) == 5'h1F)
      else $error("cable prompt with a grounded type line");
   a_reserved_direct: assert property ($rose(coupling_direct) && !phy_q |-> type_line_n == 5'h00)
      else $error("direct coupling without reserved type");
   a_rt_legal: assert property ($changed(own_rt_addr) |-> own_rt_addr != 5'h00 && own_rt_addr != 5'h1F)
      else $error("own terminal address is reserved value");
   a_err_no_xfer: assert property (select_error |-> !xfer_start)
      else $error("transfer started while selection failed");
   a_pulse_once: assert property (xfer_start |=> !xfer_start)
      else $error("transfer start longer than one cycle");
   a_start_cause: assert property (xfer_start || $rose(select_error) |-> since_q <= DEPTH + 8)
      else $error("selection result without a recent start");
endmodule
bind library_entry_select library_entry_select_asserts #(.DEPTH(DEPTH)) u_library_entry_select_asserts (
   .core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
   .waitrequest(waitrequest), .type_line_n(type_line_n), .cable_prompt_message(cable_prompt_message),
   .coupling_direct(coupling_direct), .own_rt_addr(own_rt_addr), .xfer_start(xfer_start),
   .select_error(select_error));

//--- tb_library_entry_select.sv
// self-checking bench of the library entry selector
// assumes strap_model on the strap lines and the checker bound to the design
module tb_library_entry_select import loader_select_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata, rd;
   logic waitrequest, cable_prompt_message, subtype_query, coupling_direct, center_tap_gnd, xfer_start, select_error;
   logic [4:0] type_line_n, own_rt_addr, xfer_entry;
   logic [4:0] type_gnd = 5'h00;
   logic [3:0] cfg_line_n;
   logic [3:0] cfg_gnd = 4'h0;
   int err_count = 0;
   int n_checks = 0;
   int i, k;
   always #5 core_clk = ~core_clk;
   strap_model u_strap_model (.type_gnd(type_gnd), .cfg_gnd(cfg_gnd), .type_line_n(type_line_n),
      .cfg_line_n(cfg_line_n));
   library_entry_select u_library_entry_select (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .type_line_n(type_line_n), .cfg_line_n(cfg_line_n), .cable_prompt_message(cable_prompt_message),
      .subtype_query(subtype_query), .coupling_direct(coupling_direct), .center_tap_gnd(center_tap_gnd),
      .own_rt_addr(own_rt_addr), .xfer_start(xfer_start), .xfer_entry(xfer_entry), .select_error(select_error));
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // a wait that runs out is a mismatch and ends the run
   task automatic timeout(input string what);
      check(what, 32'h0000_0000, 32'h0000_0001);
      end_sim();
   endtask
   // one avalon transfer; waitrequest and readdata are taken at the rising edge, before its updates
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (waitrequest !== 1'b0 && i < 40);
      if (waitrequest !== 1'b0) timeout("waitrequest");
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic ent(input logic [4:0] idx, input logic [31:0] w0, input logic [31:0] w1);
      bus(1'b1, A_EIDX, {27'h0, idx});
      bus(1'b1, A_EW0, w0);
      bus(1'b1, A_EW1, w1);
   endtask
   // valid entry for configuration 3 on bus 1, terminal address 0, basic protocol
   function automatic logic [31:0] ew0(input logic [3:0] fid, input logic [1:0] sub, input logic patch);
      return {7'h00, 1'b1, patch, sub, 4'h0, fid, 5'h00, 4'h1, 4'h3};
   endfunction
   function automatic logic [31:0] tg(input logic [3:0] fid, input logic mcm, input logic [1:0] ans,
      input logic [7:0] cur);
      return {8'h00, cur, ans, mcm, fid, 5'h00, 4'h1};
   endfunction
   // start a scan and judge whichever result arrives first
   task automatic scan(input logic [31:0] tgt, input logic exp_err, input logic [4:0] exp_idx);
      bus(1'b1, A_TGT, tgt);
      bus(1'b1, A_CTRL, 32'h0000_0001);
      #1;
      for (k = 0; k < 60 && xfer_start !== 1'b1 && select_error !== 1'b1; k++) begin
         @(posedge core_clk);
         #1;
      end
      if (xfer_start !== 1'b1 && select_error !== 1'b1) timeout("scan");
      check("select_error", select_error, exp_err);
      check("xfer_start", xfer_start, !exp_err);
      if (!exp_err) check("xfer_entry", xfer_entry, exp_idx);
      // back onto the rising edge so that later input changes land on it
      @(posedge core_clk);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      // no strap grounded: self test then the cable prompt
      for (k = 0; k < 1100 && cable_prompt_message !== 1'b1; k++) @(posedge core_clk);
      if (cable_prompt_message !== 1'b1) timeout("prompt");
      check("prompt", cable_prompt_message, 1'b1);
      type_gnd <= 5'h05;
      cfg_gnd <= 4'h3;
      repeat (4) @(posedge core_clk);
      bus(1'b1, A_CTRL, 32'h0000_0002);
      bus(1'b1, A_PHY, 32'h0000_0013);
      rd = 32'h0;
      for (k = 0; k < 20 && rd[8:6] !== 3'b101; k++) bus(1'b0, A_STAT, 32'h0);
      if (rd[8:6] !== 3'b101) timeout("ready");
      check("attached", rd[8:6], 3'b101);
      check("type_cfg", rd[19:11], 9'h065);
      check("own_rt", own_rt_addr, 5'h09);
      // software coupling bits drive the outputs for an ordinary type, and clear again
      check("sw_direct", {coupling_direct, center_tap_gnd}, 2'b11);
      bus(1'b1, A_PHY, 32'h0000_0010);
      bus(1'b0, A_STAT, 32'h0);
      check("sw_off", {rd[10:9], coupling_direct, center_tap_gnd}, 4'h0);
      // entry memory has no reset, so every entry is invalidated first
      for (int e = 0; e < 32; e++) ent(e[4:0], 32'h0, 32'h0);
      ent(5'h00, ew0(4'h0, 2'h0, 1'b0), 32'h0805);
      ent(5'h01, ew0(4'h0, 2'h0, 1'b1), 32'h0803);
      ent(5'h02, ew0(4'h3, 2'h0, 1'b0), 32'h0805);
      ent(5'h03, ew0(4'h4, 2'h0, 1'b0), 32'h0805);
      ent(5'h04, ew0(4'h2, 2'h0, 1'b0), 32'h0705);
      ent(5'h05, ew0(4'h1, 2'h3, 1'b0), 32'h0805);
      ent(5'h06, ew0(4'h1, 2'h2, 1'b0), 32'h0805);
      ent(5'h07, ew0(4'h1, 2'h1, 1'b0), 32'h0805);
      bus(1'b1, A_XFER, 32'h0000_000A);
      scan(tg(4'h0, 1'b1, 2'h0, 8'h03), 1'b0, 5'h01);
      bus(1'b0, A_STAT, 32'h0);
      check("ta0_patch", rd[5:4], 2'b11);
      scan(tg(4'h0, 1'b0, 2'h0, 8'h03), 1'b0, 5'h00);
      bus(1'b0, A_RES, 32'h0);
      check("words", rd[31:16], 16'h0010);
      scan(tg(4'h0, 1'b1, 2'h0, 8'h06), 1'b1, 5'h00);
      scan(tg(4'h3, 1'b0, 2'h0, 8'h01), 1'b1, 5'h00);
      scan(tg(4'h4, 1'b0, 2'h0, 8'h01), 1'b0, 5'h03);
      scan(tg(4'h2, 1'b0, 2'h0, 8'h01), 1'b1, 5'h00);
      scan(tg(4'h1, 1'b0, 2'h2, 8'h01), 1'b0, 5'h06);
      scan(tg(4'h1, 1'b0, 2'h1, 8'h01), 1'b0, 5'h07);
      scan(tg(4'h1, 1'b0, 2'h3, 8'h01), 1'b1, 5'h00);
      check("query0", subtype_query, 1'b0);
      scan(tg(4'h1, 1'b0, 2'h0, 8'h01), 1'b1, 5'h00);
      check("query", subtype_query, 1'b1);
      // reserved type: rerun self test and read coupling from the straps
      type_gnd <= 5'h1F;
      repeat (4) @(posedge core_clk);
      bus(1'b1, A_CTRL, 32'h0000_0004);
      for (k = 0; k < 1200 && coupling_direct !== 1'b1; k++) @(posedge core_clk);
      if (coupling_direct !== 1'b1) timeout("direct");
      repeat (2) @(posedge core_clk);
      check("direct", coupling_direct, 1'b1);
      check("tap", center_tap_gnd, 1'b1);
      check("own_rt_rsv", own_rt_addr, 5'h1E);
      bus(1'b0, A_STAT, 32'h0);
      check("rsv_type_cfg", rd[19:11], 9'h01F);
      end_sim();
   end
   // overall guard against a hang anywhere in the sequence
   initial begin
      #1_000_000;
      timeout("run");
   end
endmodule
